//--- hdl/radio_power_pkg.sv
// Constants and types shared by the power sequencer host and device ends
package radio_power_pkg;
    localparam int unsigned CLK_FREQ_HZ   = 125_000_000;
    localparam int unsigned POR_MAX_MS    = 110;
    localparam int unsigned ACCESS_MIN_MS = 150;
    localparam int unsigned TOGGLE_MIN_MS = 10;
    localparam int unsigned MS_DIV        = 1000;
    localparam int unsigned POR_CYCLES    =
        (CLK_FREQ_HZ / MS_DIV) * POR_MAX_MS;
    localparam int unsigned ACCESS_CYCLES =
        32'(((CLK_FREQ_HZ * 64'd1 * ACCESS_MIN_MS) + MS_DIV - 1) / MS_DIV);
    localparam int unsigned TOGGLE_CYCLES =
        32'(((CLK_FREQ_HZ * 64'd1 * TOGGLE_MIN_MS) + MS_DIV - 1) / MS_DIV);
    localparam int unsigned CNT_W         = 32;
    localparam int unsigned WORD_W        = 32;
    localparam int unsigned BIT_CNT_W     = 5;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h1f;
    localparam logic [CNT_W-1:0]     CNT_ONE  = 32'h0000_0001;

    typedef enum logic [2:0]
    {
        H_OFF     = 3'b000,
        H_WAIT    = 3'b001,
        H_READY   = 3'b010,
        H_SHIFT   = 3'b011,
        H_DISCHG  = 3'b100
    } host_state_type;
endpackage : radio_power_pkg

//--- hdl/radio_power_if.sv
// Interface joining the host and device ends of the power sequencer
`timescale 1ns/1ps
interface radio_power_if;
    logic wlan_power_enable;
    logic bluetooth_power_enable;
    logic serial_clk;
    logic serial_chip_select_n;
    logic serial_data_in;

    modport host
    (
        output wlan_power_enable,
        output bluetooth_power_enable,
        output serial_clk,
        output serial_chip_select_n,
        output serial_data_in
    );
    modport device
    (
        input  wlan_power_enable,
        input  bluetooth_power_enable,
        input  serial_clk,
        input  serial_chip_select_n,
        input  serial_data_in
    );
endinterface : radio_power_if

//--- hdl/radio_power_device.sv
// Device end: regulator enable, section resets, power-on reset, serial sample
`timescale 1ns/1ps
module radio_power_device
    import radio_power_pkg::*;
#(
    parameter int unsigned POR_LEN = POR_CYCLES
)
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    radio_power_if.device          link,
    output logic                   o_regulator_on,
    output logic                   o_wlan_reset_n,
    output logic                   o_bluetooth_reset_n,
    output logic                   o_chip_ready,
    output logic [WORD_W-1:0]      o_rx_word,
    output logic                   o_rx_valid
);
    logic [CNT_W-1:0]     por_cnt_reg, por_cnt_next;
    logic                 ready_reg, ready_next;
    logic                 sclk_prev_reg, sclk_prev_next;
    logic [WORD_W-1:0]    shift_reg, shift_next;
    logic [BIT_CNT_W-1:0] bit_reg, bit_next;
    logic [WORD_W-1:0]    word_reg, word_next;
    logic                 valid_reg, valid_next;
    logic                 reg_on;
    logic                 rise;

    assign reg_on = link.wlan_power_enable |
                    link.bluetooth_power_enable;
    assign rise   = link.serial_clk & ~sclk_prev_reg;

    always_comb
    begin
        por_cnt_next   = por_cnt_reg;
        ready_next     = ready_reg;
        sclk_prev_next = link.serial_clk;
        shift_next     = shift_reg;
        bit_next       = bit_reg;
        word_next      = word_reg;
        valid_next     = 1'b0;
        if (!reg_on)
        begin
            por_cnt_next = '0;
            ready_next   = 1'b0;
        end
        else if (!ready_reg)
        begin
            // Release at the count, never later than the limit
            if (por_cnt_reg >= POR_LEN - 1)
                ready_next = 1'b1;
            else
                por_cnt_next = por_cnt_reg + CNT_ONE;
        end
        if (link.serial_chip_select_n || !ready_reg)
            bit_next = '0;
        else if (rise)
        begin
            shift_next = {shift_reg[WORD_W-2:0], link.serial_data_in};
            bit_next   = bit_reg + 5'h01;
            if (bit_reg == LAST_BIT)
            begin
                word_next  = {shift_reg[WORD_W-2:0], link.serial_data_in};
                valid_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            por_cnt_reg   <= '0;
            ready_reg     <= 1'b0;
            sclk_prev_reg <= 1'b0;
            shift_reg     <= '0;
            bit_reg       <= '0;
            word_reg      <= '0;
            valid_reg     <= 1'b0;
        end
        else
        begin
            por_cnt_reg   <= por_cnt_next;
            ready_reg     <= ready_next;
            sclk_prev_reg <= sclk_prev_next;
            shift_reg     <= shift_next;
            bit_reg       <= bit_next;
            word_reg      <= word_next;
            valid_reg     <= valid_next;
        end
    end

    assign o_regulator_on      = reg_on;
    assign o_wlan_reset_n      = ready_reg &
                                 link.wlan_power_enable;
    assign o_bluetooth_reset_n = ready_reg &
                                 link.bluetooth_power_enable;
    assign o_chip_ready        = ready_reg;
    assign o_rx_word           = word_reg;
    assign o_rx_valid          = valid_reg;
endmodule : radio_power_device

//--- hdl/radio_power_host.sv
// Host end: enable sequencing with minimum waits and a serial word sender
`timescale 1ns/1ps
module radio_power_host
    import radio_power_pkg::*;
#(
    parameter int unsigned ACCESS_LEN = ACCESS_CYCLES,
    parameter int unsigned TOGGLE_LEN = TOGGLE_CYCLES
)
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    radio_power_if.host            link,
    input  wire logic              i_wlan_req,
    input  wire logic              i_bluetooth_req,
    input  wire logic              i_send_valid,
    input  wire logic [WORD_W-1:0] i_send_word,
    output logic                   o_send_ready,
    output logic                   o_bus_ready
);
    host_state_type       state_reg, state_next;
    logic [CNT_W-1:0]     cnt_reg, cnt_next;
    logic                 wl_reg, wl_next;
    logic                 bt_reg, bt_next;
    logic [WORD_W-1:0]    tx_reg, tx_next;
    logic [BIT_CNT_W-1:0] bit_reg, bit_next;
    logic                 sclk_reg, sclk_next;
    logic                 cs_n_reg, cs_n_next;
    logic                 any_req;
    logic                 start_frame;
    logic                 frame_done;
    logic                 wait_done;
    logic                 dischg_done;

    assign any_req     = i_wlan_req | i_bluetooth_req;
    // Word accepted only while ready and powered
    assign start_frame = (state_reg == H_READY) & any_req & i_send_valid;
    assign frame_done  = (state_reg == H_SHIFT) & sclk_reg &
                         (bit_reg == LAST_BIT);
    assign wait_done   = (cnt_reg >= ACCESS_LEN - 1);
    // Requests during the wait neither shorten nor stretch it
    assign dischg_done = (cnt_reg >= TOGGLE_LEN - 1);

    always_comb
    begin
        state_next = state_reg;
        wl_next    = wl_reg;
        bt_next    = bt_reg;
        case (state_reg)
            H_OFF:
            begin
                if (any_req)
                begin
                    wl_next    = i_wlan_req;
                    bt_next    = i_bluetooth_req;
                    state_next = H_WAIT;
                end
            end
            H_WAIT:
            begin
                // Enables track the requests in H_WAIT and H_READY, not in H_SHIFT
                wl_next = i_wlan_req;
                bt_next = i_bluetooth_req;
                if (!any_req)
                begin
                    state_next = H_DISCHG;
                end
                else if (wait_done)
                begin
                    state_next = H_READY;
                end
            end
            H_READY:
            begin
                wl_next = i_wlan_req;
                bt_next = i_bluetooth_req;
                if (!any_req)
                begin
                    state_next = H_DISCHG;
                end
                else if (i_send_valid)
                begin
                    state_next = H_SHIFT;
                end
            end
            H_SHIFT:
            begin
                // Stays until the last bit has been clocked
                if (frame_done)
                begin
                    state_next = H_READY;
                end
            end
            H_DISCHG:
            begin
                // Both enables low for the whole wait
                wl_next = 1'b0;
                bt_next = 1'b0;
                if (dischg_done)
                begin
                    state_next = H_OFF;
                end
            end
            default:
            begin
                state_next = H_OFF;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg <= H_OFF;
            wl_reg    <= 1'b0;
            bt_reg    <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            wl_reg    <= wl_next;
            bt_reg    <= bt_next;
        end
    end

    // Wait counter restarts on every change of state
    always_comb
    begin
        cnt_next = cnt_reg;
        if (state_next != state_reg)
        begin
            cnt_next = '0;
        end
        else if ((state_reg == H_WAIT) || (state_reg == H_DISCHG))
        begin
            cnt_next = cnt_reg + CNT_ONE;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // Serial sender: clock idles low, one bit per two cycles
    always_comb
    begin
        tx_next   = tx_reg;
        bit_next  = bit_reg;
        sclk_next = sclk_reg;
        cs_n_next = cs_n_reg;
        if (start_frame)
        begin
            tx_next   = i_send_word;
            bit_next  = '0;
            cs_n_next = 1'b0;
            sclk_next = 1'b0;
        end
        else if (state_reg == H_SHIFT)
        begin
            // Chip select held low across all bits
            sclk_next = ~sclk_reg;
            if (sclk_reg)
            begin
                tx_next  = {tx_reg[WORD_W-2:0], 1'b0};
                bit_next = bit_reg + 5'h01;
                if (frame_done)
                begin
                    cs_n_next = 1'b1;
                end
            end
        end
    end

    // Chip select idles high, clock idles low
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_reg   <= '0;
            bit_reg  <= '0;
            sclk_reg <= 1'b0;
            cs_n_reg <= 1'b1;
        end
        else
        begin
            tx_reg   <= tx_next;
            bit_reg  <= bit_next;
            sclk_reg <= sclk_next;
            cs_n_reg <= cs_n_next;
        end
    end

    // Link pins come straight from registers
    assign link.wlan_power_enable      = wl_reg;
    assign link.bluetooth_power_enable = bt_reg;
    assign link.serial_clk             = sclk_reg;
    assign link.serial_chip_select_n   = cs_n_reg;
    assign link.serial_data_in         = tx_reg[WORD_W-1];
    assign o_send_ready = (state_reg == H_READY) & any_req;
    assign o_bus_ready  = (state_reg == H_READY);
endmodule : radio_power_host

//--- tb/radio_power_props.sv
// Assertions on the sequencer link and the device outputs
`timescale 1ns/1ps
module radio_power_props
#(
    parameter int unsigned POR_LEN    = 20,
    parameter int unsigned TOGGLE_LEN = 10
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic wlan_power_enable,
    input wire logic bluetooth_power_enable,
    input wire logic serial_chip_select_n,
    input wire logic o_regulator_on,
    input wire logic o_wlan_reset_n,
    input wire logic o_bluetooth_reset_n,
    input wire logic o_chip_ready,
    input wire logic o_rx_valid
);
    localparam int POR_HI = POR_LEN + 1;
    logic [7:0]  low_reg;
    logic [31:0] off_reg;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Frame length and regulator off time
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            low_reg <= 8'h00;
            off_reg <= TOGGLE_LEN;
        end
        else
        begin
            low_reg <= serial_chip_select_n ? 8'h00 : low_reg + 8'h01;
            off_reg <= o_regulator_on ? 32'h0 : off_reg + 32'h1;
        end
    end
    sequence s_frame_start;
        $fell(serial_chip_select_n) && o_chip_ready;
    endsequence
    property p_word_rx;
        s_frame_start |-> ##[60:68] o_rx_valid;
    endproperty
    a_reg_or_gate: assert property (o_regulator_on ==
        (wlan_power_enable | bluetooth_power_enable)) else $error("reg on");
    a_wlan_held: assert property (!wlan_power_enable |->
        !o_wlan_reset_n) else $error("wlan reset");
    a_wlan_free: assert property (o_chip_ready && wlan_power_enable
        |-> o_wlan_reset_n) else $error("wlan release");
    a_bt_held: assert property (!bluetooth_power_enable |->
        !o_bluetooth_reset_n) else $error("bt reset");
    a_bt_free: assert property (o_chip_ready && bluetooth_power_enable
        |-> o_bluetooth_reset_n) else $error("bt release");
    a_por_bound: assert property ($rose(o_regulator_on) |->
        ##[1:POR_HI] (o_chip_ready || !o_regulator_on)) else $error("por");
    a_frame_len: assert property ($rose(serial_chip_select_n) |->
        low_reg == 8'h40) else $error("frame length");
    a_word_rx: assert property (p_word_rx) else $error("no word");
    a_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid)
        else $error("rx pulse");
    a_off_gap: assert property ($rose(o_regulator_on) |->
        off_reg >= TOGGLE_LEN) else $error("toggle gap");
endmodule : radio_power_props

//--- tb/test_radio_power_enable_sequencer.sv
// Bench joining host and device ends of the power sequencer
`timescale 1ns/1ps
module test_radio_power_enable_sequencer
    import radio_power_pkg::*;
;
    localparam int unsigned POR_LEN    = 20;
    localparam int unsigned ACCESS_LEN = 40;
    localparam int unsigned TOGGLE_LEN = 10;
    logic              i_clk;
    logic              i_rst_b;
    logic              wlan_req;
    logic              bt_req;
    logic              send_valid;
    logic [WORD_W-1:0] send_word;
    logic              send_ready;
    logic              bus_ready;
    logic              reg_on;
    logic              wlan_rst_n;
    logic              bt_rst_n;
    logic              chip_ready;
    logic [WORD_W-1:0] rx_word;
    logic              rx_valid;
    logic [31:0]       rx_q[$];
    int                error_cnt = 0;
    int                n_checks = 0;
    int                cyc = 0;
    radio_power_if link();
    radio_power_host #(.ACCESS_LEN(ACCESS_LEN), .TOGGLE_LEN(TOGGLE_LEN))
    radio_power_host_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link),
        .i_wlan_req(wlan_req), .i_bluetooth_req(bt_req),
        .i_send_valid(send_valid), .i_send_word(send_word),
        .o_send_ready(send_ready), .o_bus_ready(bus_ready));
    radio_power_device #(.POR_LEN(POR_LEN))
    radio_power_device_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link),
        .o_regulator_on(reg_on), .o_wlan_reset_n(wlan_rst_n),
        .o_bluetooth_reset_n(bt_rst_n), .o_chip_ready(chip_ready),
        .o_rx_word(rx_word), .o_rx_valid(rx_valid));
    radio_power_props #(.POR_LEN(POR_LEN), .TOGGLE_LEN(TOGGLE_LEN))
    radio_power_props_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .wlan_power_enable(link.wlan_power_enable),
        .bluetooth_power_enable(link.bluetooth_power_enable),
        .serial_chip_select_n(link.serial_chip_select_n),
        .o_regulator_on(reg_on), .o_wlan_reset_n(wlan_rst_n),
        .o_bluetooth_reset_n(bt_rst_n), .o_chip_ready(chip_ready),
        .o_rx_valid(rx_valid));
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1)
            rx_q.push_back(rx_word);
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk
    task t_power(input logic w, input logic b);
        int n;
        wlan_req <= w;
        bt_req <= b;
        repeat (2) @(posedge i_clk);
        chk(reg_on, 1'b1);
        chk(chip_ready, 1'b0);
        n = 0;
        while (chip_ready !== 1'b1 && n < POR_LEN + 2)
        begin
            @(posedge i_clk);
            n++;
        end
        chk(chip_ready, 1'b1);
        chk(wlan_rst_n, w);
        chk(bt_rst_n, b);
        wlan_req <= 1'b0;
        bt_req <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(reg_on, 1'b0);
        chk({wlan_rst_n, bt_rst_n}, 2'b00);
        wlan_req <= w;
        bt_req <= b;
        n = 0;
        while (reg_on !== 1'b1 && n < 100)
        begin
            @(posedge i_clk);
            n++;
        end
        chk(n >= TOGGLE_LEN - 2, 1'b1);
        wlan_req <= 1'b0;
        bt_req <= 1'b0;
        repeat (TOGGLE_LEN + 4) @(posedge i_clk);
        $display("t_power %0d%0d done", w, b);
    endtask : t_power
    task t_send(input logic [31:0] w0, input logic [31:0] w1);
        int n;
        wlan_req <= 1'b1;
        n = 0;
        while (bus_ready !== 1'b1 && n < 100)
        begin
            @(posedge i_clk);
            n++;
        end
        chk(chip_ready, 1'b1);
        chk(bus_ready, 1'b1);
        chk(n >= ACCESS_LEN, 1'b1);
        send_word <= w0;
        send_valid <= 1'b1;
        @(posedge i_clk);
        send_word <= w1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (send_ready !== 1'b1 && n < 100);
        send_valid <= 1'b0;
        repeat (80) @(posedge i_clk);
        chk(rx_q.size(), 32'h2);
        chk(rx_q[0], w0);
        chk(rx_q[1], w1);
        wlan_req <= 1'b0;
        $display("t_send done");
    endtask : t_send
    task final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    initial
    begin
        i_rst_b = 1'b0;
        wlan_req = 1'b0;
        bt_req = 1'b0;
        send_valid = 1'b0;
        send_word = 32'h0;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        t_power(1'b1, 1'b1);
        t_power(1'b1, 1'b0);
        t_power(1'b0, 1'b1);
        t_send(32'h8000_0001, 32'h5a3c_96e1);
        final_report();
    end
endmodule : test_radio_power_enable_sequencer
